// ---- hw/clock_host_pkg.sv ----
package clock_host_pkg;

    // ---------------------------------------------------------------
    // device register map (registers live in the device)
    // ---------------------------------------------------------------
    localparam logic [7:0] MAIN_OSC_RUN_CONTROL_ADDR = 8'h00;
    localparam logic [7:0] SUB_OSC_RUN_CONTROL_ADDR = 8'h01;
    localparam logic [7:0] FAST_INTERNAL_RUN_CONTROL_ADDR = 8'h02;
    localparam logic [7:0] MID_INTERNAL_RUN_CONTROL_ADDR = 8'h03;
    localparam logic [7:0] SLOW_INTERNAL_RUN_CONTROL_ADDR = 8'h04;
    localparam logic [7:0] SYSTEM_CLOCK_DIVIDER_CTRL_ADDR = 8'h05;
    localparam logic [7:0] SYSTEM_CLOCK_SOURCE_SELECT_ADDR = 8'h06;
    localparam logic [7:0] MAIN_OSC_MODE_CONTROL_ADDR = 8'h07;
    localparam logic [7:0] PLL_CONTROL_TWO_ADDR = 8'h08;
    localparam logic [7:0] USB_DIVIDER_CONTROL_ADDR = 8'h09;
    localparam logic [7:0] FLL_CONTROL_ADDR = 8'h0A;

    // ---------------------------------------------------------------
    // fields
    // ---------------------------------------------------------------
    localparam int STOP_BIT = 0;
    localparam int EXTERNAL_CLOCK_SELECT_BIT = 6;
    localparam int USB_DIV_V1_LSB = 4;
    localparam int USB_DIV_W = 4;
    localparam logic [7:0] DIVIDER_MAX_ALL = 8'hFF;

    // clock source codes
    localparam logic [2:0] SRC_FAST_INTERNAL = 3'h0;
    localparam logic [2:0] SRC_MID_INTERNAL = 3'h1;
    localparam logic [2:0] SRC_SLOW_INTERNAL = 3'h2;
    localparam logic [2:0] SRC_MAIN_OSC = 3'h3;
    localparam logic [2:0] SRC_SUB_OSC = 3'h4;
    localparam logic [2:0] SRC_PLL = 3'h5;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int SETTLE_NS = 1000;
    localparam int SETTLE_CYCLES = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int READBACK_WAIT = 2;

    // frequency limits in MHz, first and second variant
    localparam int V1_CORE_MAX_MHZ = 48;
    localparam int V1_PB_MAX_MHZ = 32;
    localparam int V1_PCD_MAX_MHZ = 64;
    localparam int V2_CORE_MAX_MHZ = 100;
    localparam int V2_PBC_MAX_MHZ = 50;
    localparam int FLASH_MIN_MHZ = 4;
    localparam int USB_MHZ = 48;
    localparam int MAIN_IN_MIN_MHZ = 1;
    localparam int MAIN_IN_MAX_MHZ = 20;

    typedef enum logic [2:0] {
        OP_OSC_RUN,
        OP_OSC_STOP,
        OP_SELECT_SOURCE,
        OP_SET_DIVIDERS,
        OP_SET_USB,
        OP_EXT_CLOCK
    } op_t;

    typedef struct packed {
        op_t op;
        logic [2:0] target;
        logic [31:0] data;
    } cmd_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage : clock_host_pkg

// ---- hw/clock_host.sv ----
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - first variant: core/A 48, B 32, C/D 64 MHz ceilings
// - second variant: core/A/D 100, B/C 50 MHz ceilings
// - flash clock at least 4 MHz while programming or erasing (FLASH_MIN_MHZ is never checked here)
// - USB clock exactly 48 MHz from clock tree settings
// - second variant with fast oscillator feeding loop: enable frequency lock
// - software waits after any source switch before dependent work
// - frequency change: write, read back, then continue
// - unused dividers at largest ratio, unneeded oscillators stopped (left to the caller; divider data is written as given)
// - external source changes frequency only while main oscillator stopped
// - first variant main input between 1 and 20 MHz
module clock_host
    import clock_host_pkg::*;
#(
    parameter bit VARIANT_TWO = 1'b0,
    parameter int SETTLE = SETTLE_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire cmd_t cmd,
    input wire logic fast_feeds_pll,
    input wire logic [7:0] core_mhz,
    input wire logic [7:0] pa_mhz,
    input wire logic [7:0] pb_mhz,
    input wire logic [7:0] pc_mhz,
    input wire logic [7:0] pd_mhz,
    input wire logic [7:0] usb_mhz,
    input wire logic [7:0] main_in_mhz,
    output logic cmd_ready,
    output logic cmd_done,
    output logic cmd_error,
    output logic [31:0] cmd_rdata,
    output reg_req_t reg_req,
    input wire logic reg_ack,
    input wire logic [31:0] reg_rdata,
    output logic ext_clock_changeable
);

    // ---------------------------------------------------------------
    // sequencing
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        IDLE, FLL_WRITE, WRITE, READ, WAIT_RD, SETTLE_WAIT, FINISH
    } state_t;

    state_t state_q;
    cmd_t cmd_q;
    logic [31:0] count_q;
    logic [7:0] addr_w;
    logic [31:0] data_w;
    logic bad_limits;
    logic main_stopped_q;
    logic ack_s1_q, ack_s2_q;
    logic [31:0] rdata_q;

    // ack comes from the device pins, so sync it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end else begin
            ack_s1_q <= reg_ack;
            ack_s2_q <= ack_s1_q;
        end
    end

    // rdata taken only at the readback handshake; the synced ack lags the
    // device's, so later copies would catch the stale bus value
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (state_q == WAIT_RD && ack_s2_q) begin
            rdata_q <= reg_rdata;
        end
    end

    // ---------------------------------------------------------------
    // limits checked before any divider or usb write
    // ---------------------------------------------------------------
    always_comb begin
        bad_limits = 1'b0;
        if (cmd.op == OP_SET_DIVIDERS) begin
            if (!VARIANT_TWO) begin
                bad_limits = (core_mhz > 8'(V1_CORE_MAX_MHZ))
                    || (pa_mhz > 8'(V1_CORE_MAX_MHZ))
                    || (pb_mhz > 8'(V1_PB_MAX_MHZ))
                    || (pc_mhz > 8'(V1_PCD_MAX_MHZ))
                    || (pd_mhz > 8'(V1_PCD_MAX_MHZ));
            end else begin
                bad_limits = (core_mhz > 8'(V2_CORE_MAX_MHZ))
                    || (pa_mhz > 8'(V2_CORE_MAX_MHZ))
                    || (pd_mhz > 8'(V2_CORE_MAX_MHZ))
                    || (pb_mhz > 8'(V2_PBC_MAX_MHZ))
                    || (pc_mhz > 8'(V2_PBC_MAX_MHZ));
            end
        end else if (cmd.op == OP_SET_USB) begin
            bad_limits = usb_mhz != 8'(USB_MHZ);
        end else if (cmd.op == OP_SELECT_SOURCE) begin
            bad_limits = cmd.data[2:0] > SRC_PLL;
        end else if (cmd.op == OP_EXT_CLOCK) begin
            // frequency changes only with main oscillator stopped
            bad_limits = !main_stopped_q;
        end else if (cmd.op == OP_OSC_RUN && cmd.target == SRC_MAIN_OSC
                     && !VARIANT_TWO) begin
            bad_limits = (main_in_mhz < 8'(MAIN_IN_MIN_MHZ))
                || (main_in_mhz > 8'(MAIN_IN_MAX_MHZ));
        end
    end

    // ---------------------------------------------------------------
    // address and data of the write
    // ---------------------------------------------------------------
    always_comb begin
        addr_w = MID_INTERNAL_RUN_CONTROL_ADDR;
        data_w = 32'h0000_0000;
        unique case (cmd_q.op)
            OP_OSC_RUN, OP_OSC_STOP: begin
                unique case (cmd_q.target)
                    SRC_MAIN_OSC: addr_w = MAIN_OSC_RUN_CONTROL_ADDR;
                    SRC_SUB_OSC: addr_w = SUB_OSC_RUN_CONTROL_ADDR;
                    SRC_FAST_INTERNAL: addr_w = FAST_INTERNAL_RUN_CONTROL_ADDR;
                    SRC_SLOW_INTERNAL: addr_w = SLOW_INTERNAL_RUN_CONTROL_ADDR;
                    default: addr_w = MID_INTERNAL_RUN_CONTROL_ADDR;
                endcase
                data_w[STOP_BIT] = cmd_q.op == OP_OSC_STOP;
            end
            OP_SELECT_SOURCE: begin
                addr_w = SYSTEM_CLOCK_SOURCE_SELECT_ADDR;
                data_w = {29'h0, cmd_q.data[2:0]};
            end
            OP_SET_DIVIDERS: begin
                addr_w = SYSTEM_CLOCK_DIVIDER_CTRL_ADDR;
                data_w = cmd_q.data;
            end
            OP_SET_USB: begin
                if (VARIANT_TWO) begin
                    addr_w = USB_DIVIDER_CONTROL_ADDR;
                    data_w = {28'h0, cmd_q.data[USB_DIV_W-1:0]};
                end else begin
                    addr_w = PLL_CONTROL_TWO_ADDR;
                    data_w = cmd_q.data;
                    data_w[USB_DIV_V1_LSB +: USB_DIV_W] = cmd_q.data[USB_DIV_W-1:0];
                end
            end
            OP_EXT_CLOCK: begin
                addr_w = MAIN_OSC_MODE_CONTROL_ADDR;
                data_w[EXTERNAL_CLOCK_SELECT_BIT] = cmd_q.data[0];
            end
            default: begin
                addr_w = MID_INTERNAL_RUN_CONTROL_ADDR;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // main sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= IDLE;
            cmd_q <= '0;
            count_q <= 32'h0000_0000;
            cmd_ready <= 1'b1;
            cmd_done <= 1'b0;
            cmd_error <= 1'b0;
            cmd_rdata <= 32'h0000_0000;
            reg_req <= '0;
        end else begin
            cmd_done <= 1'b0;
            cmd_error <= 1'b0;
            unique case (state_q)
                IDLE: begin
                    if (cmd_valid) begin
                        if (bad_limits) begin
                            cmd_done <= 1'b1;
                            cmd_error <= 1'b1;
                        end else begin
                            cmd_q <= cmd;
                            cmd_ready <= 1'b0;
                            // usb off the fast oscillator needs frequency lock first
                            if (VARIANT_TWO && cmd.op == OP_SET_USB && fast_feeds_pll) begin
                                state_q <= FLL_WRITE;
                            end else begin
                                state_q <= WRITE;
                            end
                        end
                    end
                end
                FLL_WRITE: begin
                    reg_req <= '{addr: FLL_CONTROL_ADDR, wdata: 32'h0000_0001,
                                 wr: 1'b1, rd: 1'b0};
                    if (ack_s2_q) begin
                        reg_req <= '0;
                        state_q <= WRITE;
                    end
                end
                WRITE: begin
                    reg_req <= '{addr: addr_w, wdata: data_w, wr: 1'b1, rd: 1'b0};
                    if (ack_s2_q && reg_req.wr) begin
                        reg_req <= '0;
                        count_q <= 32'(READBACK_WAIT);
                        state_q <= READ;
                    end
                end
                READ: begin
                    // ack must fall before the readback begins
                    if (count_q != 32'h0000_0000) begin
                        count_q <= count_q - 32'h0000_0001;
                    end else if (!ack_s2_q) begin
                        reg_req <= '{addr: addr_w, wdata: 32'h0000_0000,
                                     wr: 1'b0, rd: 1'b1};
                        state_q <= WAIT_RD;
                    end
                end
                WAIT_RD: begin
                    if (ack_s2_q) begin
                        reg_req <= '0;
                        count_q <= 32'(SETTLE);
                        state_q <= SETTLE_WAIT;
                    end
                end
                SETTLE_WAIT: begin
                    // covers stretched peripheral periods after a switch
                    if (count_q != 32'h0000_0000) begin
                        count_q <= count_q - 32'h0000_0001;
                    end else begin
                        state_q <= FINISH;
                    end
                end
                FINISH: begin
                    cmd_rdata <= rdata_q;
                    cmd_done <= 1'b1;
                    // device keeps old source if new one was not running
                    cmd_error <= cmd_q.op == OP_SELECT_SOURCE
                        && rdata_q[2:0] != cmd_q.data[2:0];
                    cmd_ready <= 1'b1;
                    state_q <= IDLE;
                end
                default: begin
                    state_q <= IDLE;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // main oscillator run state as last written
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            main_stopped_q <= 1'b1;
            ext_clock_changeable <= 1'b1;
        end else if (state_q == FINISH && cmd_q.target == SRC_MAIN_OSC
                     && (cmd_q.op == OP_OSC_RUN || cmd_q.op == OP_OSC_STOP)) begin
            main_stopped_q <= cmd_q.op == OP_OSC_STOP;
            ext_clock_changeable <= cmd_q.op == OP_OSC_STOP;
        end
    end

endmodule : clock_host

`default_nettype wire

// ---- dv/clock_host_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
module clock_host_monitor
    import clock_host_pkg::*;
#(
    parameter bit VARIANT_TWO = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire cmd_t cmd,
    input wire logic [7:0] core_mhz,
    input wire logic [7:0] usb_mhz,
    input wire logic cmd_ready,
    input wire logic cmd_done,
    input wire logic cmd_error,
    input wire reg_req_t reg_req,
    input wire logic reg_ack,
    input wire logic ext_clock_changeable
);
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    localparam logic [7:0] CORE_MAX = VARIANT_TWO ? 8'h64 : 8'h30;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic take;
    assign take = cmd_valid && cmd_ready;

    a_reset_idle_state: assert property (disable iff (1'b0) !rst_n |=> cmd_ready && !cmd_done
        && reg_req == '0 && ext_clock_changeable) else $error("reset state wrong");
    a_done_one_cycle: assert property (cmd_done |=> !cmd_done) else $error("done too long");
    a_error_with_done: assert property (cmd_error |-> cmd_done) else $error("error alone");
    a_source_code_refused: assert property (take && cmd.op == OP_SELECT_SOURCE && cmd.data[2:0] > 3'h5
        |=> cmd_done && cmd_error && reg_req == '0) else $error("bad source taken");
    a_core_limit_refused: assert property (take && cmd.op == OP_SET_DIVIDERS && core_mhz > CORE_MAX
        |=> cmd_done && cmd_error) else $error("core limit passed");
    a_usb_rate_refused: assert property (take && cmd.op == OP_SET_USB && usb_mhz != 8'h30
        |=> cmd_done && cmd_error) else $error("usb rate passed");
    a_ext_running_refused: assert property (take && cmd.op == OP_EXT_CLOCK && !ext_clock_changeable
        |=> cmd_done && cmd_error) else $error("ext clock while running");
    a_req_held_stable: assert property ((reg_req.wr || reg_req.rd) && !reg_ack
        |=> $stable(reg_req)) else $error("request moved before ack");
    a_write_then_read: assert property ($fell(reg_req.wr) |-> ##[1:60] reg_req.rd)
        else $error("no readback");
    a_settle_after_read: assert property ($fell(reg_req.rd) |-> !cmd_done [*3])
        else $error("done before settle");
    c_done_ok: cover property (cmd_done && !cmd_error);
    c_done_err: cover property (cmd_done && cmd_error);
    c_ack_seen: cover property ($rose(reg_ack));
endmodule : clock_host_monitor
bind clock_host clock_host_monitor #(.VARIANT_TWO(VARIANT_TWO)) i_mon (.clk(clk), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd(cmd), .core_mhz(core_mhz), .usb_mhz(usb_mhz),
    .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_error(cmd_error), .reg_req(reg_req),
    .reg_ack(reg_ack), .ext_clock_changeable(ext_clock_changeable));
`default_nettype wire

// ---- dv/clock_device_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module clock_device_model
    import clock_host_pkg::*;
#(
    parameter bit FAST_OPT_ON = 1'b1,
    parameter bit WDT_OPT_ON = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire reg_req_t reg_req,
    output logic reg_ack,
    output logic [31:0] reg_rdata,
    output logic crystal_output_pin_hiz,
    output logic wdt_run,
    output logic [7:0] last_wr_addr
);
    logic [31:0] regs [0:10];
    logic [3:0] wait_q;
    logic [31:0] last_q;
    assign wdt_run = WDT_OPT_ON;
    assign crystal_output_pin_hiz = regs[7][EXTERNAL_CLOCK_SELECT_BIT];
    // stale data inverts so a late sample never looks valid
    assign reg_rdata = reg_ack ? regs[reg_req.addr[3:0]] : ~last_q;

    function automatic logic running(input logic [2:0] c);
        case (c)
            SRC_FAST_INTERNAL: return !regs[2][STOP_BIT];
            SRC_MID_INTERNAL: return !regs[3][STOP_BIT];
            SRC_SLOW_INTERNAL: return !regs[4][STOP_BIT];
            SRC_MAIN_OSC: return !regs[0][STOP_BIT];
            SRC_SUB_OSC: return !regs[1][STOP_BIT];
            SRC_PLL: return !regs[8][STOP_BIT];
            default: return 1'b0;
        endcase
    endfunction : running

    always_ff @(posedge clk) begin
        if (!rst_n || !(reg_req.wr || reg_req.rd)) begin
            wait_q <= 4'h0;
            reg_ack <= 1'b0;
        end else begin
            wait_q <= (wait_q == 4'hF) ? wait_q : wait_q + 4'h1;
            reg_ack <= (wait_q >= (slow ? 4'h6 : 4'h0));
        end
        if (reg_ack) begin
            last_q <= reg_rdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 11; i++) begin
                regs[i] <= 32'h1;
            end
            regs[2] <= {31'h0, !FAST_OPT_ON};
            regs[3] <= 32'h0;
            regs[6] <= {29'h0, SRC_MID_INTERNAL};
            regs[7] <= 32'h0;
            last_wr_addr <= 8'h0;
        end else if (reg_req.wr && reg_ack) begin
            last_wr_addr <= reg_req.addr;
            if (reg_req.addr != SYSTEM_CLOCK_SOURCE_SELECT_ADDR) begin
                regs[reg_req.addr[3:0]] <= reg_req.wdata;
            end else if (running(reg_req.wdata[2:0])) begin
                regs[6] <= reg_req.wdata;
            end
        end
    end
endmodule : clock_device_model
`default_nettype wire

// ---- dv/oscillator_clock_source_control_test.sv ----
`timescale 1ns/1ns
`default_nettype none
module oscillator_clock_source_control_test;
    import clock_host_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid = 1'b0;
    cmd_t cmd = '0;
    logic slow = 1'b0;
    logic [7:0] mhz [0:6] = '{8'h30, 8'h30, 8'h20, 8'h40, 8'h40, 8'h30, 8'h0A};
    logic cmd_ready, cmd_done, cmd_error, reg_ack, ext_clock_changeable, crystal_output_pin_hiz, wdt_run;
    logic [31:0] cmd_rdata, reg_rdata, got_data;
    logic [7:0] last_wr_addr;
    logic got_err;
    reg_req_t reg_req;
    int err_count = 0;
    int n_compared = 0;
    always #2 clk = ~clk;

    clock_host #(.VARIANT_TWO(1'b0), .SETTLE(4)) i_dut (.clk(clk), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd(cmd), .fast_feeds_pll(1'b0), .core_mhz(mhz[0]),
        .pa_mhz(mhz[1]), .pb_mhz(mhz[2]), .pc_mhz(mhz[3]), .pd_mhz(mhz[4]), .usb_mhz(mhz[5]),
        .main_in_mhz(mhz[6]), .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_error(cmd_error),
        .cmd_rdata(cmd_rdata), .reg_req(reg_req), .reg_ack(reg_ack), .reg_rdata(reg_rdata),
        .ext_clock_changeable(ext_clock_changeable));
    clock_device_model i_dev (.clk(clk), .rst_n(rst_n), .slow(slow), .reg_req(reg_req),
        .reg_ack(reg_ack), .reg_rdata(reg_rdata), .crystal_output_pin_hiz(crystal_output_pin_hiz), .wdt_run(wdt_run),
        .last_wr_addr(last_wr_addr));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    task automatic cmp_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : cmp_bit

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : cmp_word

    // one command, bounded waits; inputs move 1 ns after the edge
    task automatic run_cmd(input op_t op, input logic [2:0] tgt, input logic [31:0] data);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 400) begin
            @(posedge clk);
            #1;
            n++;
        end
        cmd_valid = 1'b1;
        cmd = '{op, tgt, data};
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        while (cmd_done !== 1'b1 && n < 400) begin
            @(posedge clk);
            #1;
            n++;
        end
        got_err = cmd_error;
        got_data = cmd_rdata;
        // one idle edge so back-to-back answers stay separate pulses
        @(posedge clk);
        #1;
        if (n >= 400) begin
            err_count++;
            finish_test();
        end
    endtask : run_cmd

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_state();
        cmp_bit(cmd_ready, 1'b1);
        cmp_bit(ext_clock_changeable, 1'b1);
        cmp_word(i_dev.regs[6], {29'h0, SRC_MID_INTERNAL});
        cmp_bit(wdt_run, 1'b1);
    endtask : t_reset_state

    task automatic t_start_main_slow();
        slow = 1'b1;
        run_cmd(OP_OSC_RUN, SRC_MAIN_OSC, 32'h0);
        slow = 1'b0;
        cmp_bit(got_err, 1'b0);
        cmp_bit(got_data[STOP_BIT], 1'b0);
        cmp_bit(ext_clock_changeable, 1'b0);
        cmp_bit(i_dev.regs[1][STOP_BIT], 1'b1);
        run_cmd(OP_EXT_CLOCK, SRC_MAIN_OSC, 32'h40);
        cmp_bit(got_err, 1'b1);
        cmp_bit(crystal_output_pin_hiz, 1'b0);
    endtask : t_start_main_slow

    // slow, sub and loop are stopped; code 6 and 7 name no oscillator
    task automatic t_select_sources();
        logic [7:0] exp_err;
        exp_err = 8'hF4;
        for (int c = 0; c < 8; c++) begin
            run_cmd(OP_SELECT_SOURCE, c[2:0], {29'h0, c[2:0]});
            cmp_bit(got_err, exp_err[c]);
        end
        cmp_word(i_dev.regs[6], {29'h0, SRC_MAIN_OSC});
    endtask : t_select_sources

    // one clock at a time one step over its ceiling, then all at it
    task automatic t_divider_limits();
        logic [7:0] top [0:4];
        top = '{8'h30, 8'h30, 8'h20, 8'h40, 8'h40};
        for (int i = 0; i < 5; i++) begin
            mhz[i] = top[i] + 8'h1;
            run_cmd(OP_SET_DIVIDERS, 3'h0, {24'h0, DIVIDER_MAX_ALL});
            cmp_bit(got_err, 1'b1);
            mhz[i] = top[i];
        end
        run_cmd(OP_SET_DIVIDERS, 3'h0, {24'h0, DIVIDER_MAX_ALL});
        cmp_bit(got_err, 1'b0);
        mhz[5] = 8'h2F;
        run_cmd(OP_SET_USB, 3'h0, 32'h10);
        cmp_bit(got_err, 1'b1);
        mhz[5] = 8'h30;
        run_cmd(OP_SET_USB, 3'h0, 32'h10);
        cmp_bit(got_err, 1'b0);
        cmp_word({24'h0, last_wr_addr}, {24'h0, PLL_CONTROL_TWO_ADDR});
    endtask : t_divider_limits

    task automatic t_external_clock();
        logic [7:0] rate [0:2];
        rate = '{8'h15, 8'h00, 8'h14};
        run_cmd(OP_SELECT_SOURCE, SRC_MID_INTERNAL, {29'h0, SRC_MID_INTERNAL});
        run_cmd(OP_OSC_STOP, SRC_MAIN_OSC, 32'h1);
        cmp_bit(ext_clock_changeable, 1'b1);
        run_cmd(OP_EXT_CLOCK, SRC_MAIN_OSC, 32'h1);
        cmp_bit(got_err, 1'b0);
        cmp_bit(crystal_output_pin_hiz, 1'b1);
        for (int i = 0; i < 3; i++) begin
            mhz[6] = rate[i];
            run_cmd(OP_OSC_RUN, SRC_MAIN_OSC, 32'h0);
            cmp_bit(got_err, i < 2);
        end
        cmp_bit(ext_clock_changeable, 1'b0);
    endtask : t_external_clock

    initial begin
        repeat (4) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_reset_state();
        t_start_main_slow();
        t_select_sources();
        t_divider_limits();
        t_external_clock();
        finish_test();
    end
endmodule : oscillator_clock_source_control_test
`default_nettype wire
